//--- dv/baro_event_regs_assertions.sv
`timescale 1ns/100ps
module baro_event_regs_assertions #(
  parameter logic [7:0] IDENT_VALUE = 8'h5A, // arbitrary value
  parameter int TRIM_WORDS = 8
) (
  input wire logic core_clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  input wire baro_regs_pkg::reg_req_s req_i, // byte access
  input wire logic [7:0] rdata_o, // read byte
  input wire logic rvalid_o, // read answer
  input wire logic conv_valid_i, // conversion strobe
  input wire baro_regs_pkg::conv_s conv_i, // conversion data
  input wire baro_regs_pkg::core_cfg_s cfg_o, // core configuration
  input wire logic [23:0] pressure_o, // shown pressure
  input wire logic event_o, // event level
  input wire logic filter_reset_o, // filter clear pulse
  input wire logic [$clog2(TRIM_WORDS)-1:0] trim_addr_i, // trim address
  input wire logic [7:0] trim_data_o, // trim word
  input wire logic trim_busy_o // trim reload
);
  import baro_regs_pkg::*;
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_read_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("read got no answer");
  a_answer_cause: assert property (rvalid_o |-> $past(req_i.rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!$past(req_i.rd) |-> $stable(rdata_o))
    else $error("read byte moved without read");
  a_ident_read: assert property (req_i.rd && req_i.start && req_i.addr == 7'h0F
    |=> rdata_o == IDENT_VALUE) else $error("identity byte wrong");
  a_reserved_zero: assert property (req_i.rd && req_i.start
    && req_i.addr inside {[7'h1B:7'h24]} |=> rdata_o == 8'h00)
    else $error("reserved read not zero");
  a_event_cause: assert property ($rose(event_o) |-> $past(conv_valid_i))
    else $error("event rose without conversion");
  a_event_drop: assert property ($fell(event_o)
    |-> $past(conv_valid_i) || $past(req_i.rd) || $past(req_i.wr))
    else $error("event fell without cause");
  a_press_cause: assert property ($changed(pressure_o)
    |-> $past(conv_valid_i) || $past(req_i.wr)) else $error("pressure moved alone");
  a_filter_pulse: assert property (filter_reset_o |-> rvalid_o && rdata_o == 8'h00)
    else $error("filter pulse without zero read");
  a_boot_start: assert property ($rose(trim_busy_o) |-> $past(req_i.wr))
    else $error("reload began without write");
  a_boot_len: assert property ($fell(trim_busy_o) |-> $past(trim_busy_o, 8))
    else $error("reload too short");
  // main scenarios seen
  cover property ($rose(event_o));
  cover property (filter_reset_o);
  cover property ($fell(trim_busy_o));
endmodule

bind baro_event_regs baro_event_regs_assertions #(
  .IDENT_VALUE(IDENT_VALUE), .TRIM_WORDS(TRIM_WORDS)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .conv_valid_i(conv_valid_i), .conv_i(conv_i), .cfg_o(cfg_o),
  .pressure_o(pressure_o), .event_o(event_o), .filter_reset_o(filter_reset_o),
  .trim_addr_i(trim_addr_i), .trim_data_o(trim_data_o), .trim_busy_o(trim_busy_o));

//--- dv/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic core_clk_i, // core clock
  output baro_regs_pkg::reg_req_s req_o, // byte access
  input wire logic [7:0] rdata_i, // read byte
  input wire logic rvalid_i // read answer
);
  import baro_regs_pkg::*;
  initial req_o = '0;
  // addresses of the register map
  function automatic logic listed(input logic [6:0] a);
    return a inside {[7'h0B:7'h0D], [7'h0F:7'h12], [7'h14:7'h1A], [7'h25:7'h2C], 7'h33};
  endfunction
  // one byte; released lines show inverted values so stale data cannot pass
  task automatic xfer(input logic st, input logic w, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    q = 8'hxx;
    if (w && !listed(a)) return;
    @(negedge core_clk_i);
    req_o <= '{start: st, addr: a, wr: w, rd: !w, wdata: d};
    @(negedge core_clk_i);
    req_o <= '{start: 1'b0, addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    // the answer stands for one cycle only: take it at the release edge
    if (!w && rvalid_i === 1'b1) q = rdata_i;
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import baro_regs_pkg::*;
  localparam logic [7:0] ID_CODE = 8'hA5; // arbitrary value
  localparam logic [23:0] P0 = 24'h3F_0000;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic conv_valid_i = 1'b0;
  conv_s conv_i = '0;
  logic [2:0] trim_addr_i = 3'h3;
  reg_req_s req;
  logic [7:0] rdata_o, trim_data_o, q;
  logic rvalid_o, event_o, trim_busy_o, filt;
  core_cfg_s cfg;
  logic [23:0] pressure_o;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [23:0] dp [3] = '{24'h01_0001, 24'h01_0000, 24'hFE_FFFF};
  logic ev [3] = '{1'b1, 1'b0, 1'b1};
  always #20 core_clk_i = ~core_clk_i;
  baro_event_regs #(.IDENT_VALUE(ID_CODE)) u_baro_event_regs (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .conv_valid_i(conv_valid_i), .conv_i(conv_i), .cfg_o(cfg),
    .pressure_o(pressure_o), .event_o(event_o), .filter_reset_o(filt),
    .trim_addr_i(trim_addr_i), .trim_data_o(trim_data_o), .trim_busy_o(trim_busy_o));
  host_model u_host_model (
    .core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata_o), .rvalid_i(rvalid_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic creg(input logic st, input logic [6:0] a, input logic [7:0] e);
    u_host_model.xfer(st, 1'b0, a, 8'h00, q);
    cmp($sformatf("reg %h", a), {16'h0, e}, {16'h0, q});
  endtask
  task automatic wr(input logic st, input logic [6:0] a, input logic [7:0] d);
    u_host_model.xfer(st, 1'b1, a, d, q);
  endtask
  task automatic cv(input logic [23:0] p);
    @(negedge core_clk_i);
    conv_valid_i <= 1'b1;
    conv_i <= '{pressure: p, temperature: 16'h1234};
    @(negedge core_clk_i);
    conv_valid_i <= 1'b0;
  endtask
  task automatic cev(input logic e);
    cmp("event", {23'h0, e}, {23'h0, event_o});
  endtask
  // the wait is bounded at 20 cycles, so a stuck busy cannot hang the run
  task automatic wait_trim();
    for (int n = 0; n < 20 && trim_busy_o !== 1'b0; n++) @(negedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, well above the expected run of under two hundred cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge core_clk_i);
    resetn_i <= 1'b1;
    wait_trim();
    cmp("trim", 24'h83, {16'h0, trim_data_o});
    cmp("cfg", 24'h10, {16'h0, cfg.control_two});
    for (int a = 'h0B; a <= 'h1B; a++)
      creg(1, 7'(a), a == 'h11 ? 8'h10 : a == 'h0F ? ID_CODE : 8'h00);
    wr(1, 7'h0F, 8'hFF);
    creg(1, 7'h0F, ID_CODE);
    wr(1, 7'h0C, 8'h00);
    wr(0, 7'h0D, 8'h01);
    creg(1, 7'h0C, 8'h00);
    creg(0, 7'h0D, 8'h01);
    wr(1, 7'h0B, 8'h01);
    cv(P0);
    cev(1'b0);
    wr(1, 7'h0B, 8'h09);
    cv(P0);
    cev(1'b1);
    creg(1, 7'h25, 8'h05);
    wr(1, 7'h0B, 8'h2B);
    cv(P0);
    cmp("pressure", 24'h0, pressure_o);
    creg(1, 7'h0B, 8'h0B);
    creg(1, 7'h17, 8'h3F);
    foreach (dp[i]) begin
      cv(P0 + dp[i]);
      cmp("pressure", dp[i], pressure_o);
      cev(ev[i]);
    end
    creg(1, 7'h25, 8'h06);
    creg(1, 7'h29, 8'hFF);
    creg(0, 7'h2A, 8'hFE);
    wr(1, 7'h0B, 8'h0F);
    cv(P0 - 24'h01_0001);
    cv(P0);
    cev(1'b1);
    creg(1, 7'h25, 8'h06);
    cev(1'b0);
    wr(1, 7'h0B, 8'h19);
    creg(1, 7'h17, 8'h00);
    cv(P0);
    cmp("pressure", P0, pressure_o);
    wr(1, 7'h18, 8'h34);
    wr(0, 7'h19, 8'h12);
    wr(1, 7'h0B, 8'h89);
    cv(P0);
    cmp("pressure", P0 - 24'h1234, pressure_o);
    creg(1, 7'h0B, 8'h09);
    cv(P0 + 24'h01_0000);
    cev(1'b0);
    wr(1, 7'h0B, 8'h49);
    cv(P0);
    cmp("pressure", P0, pressure_o);
    creg(1, 7'h27, 8'h03);
    creg(1, 7'h2A, 8'h3F);
    creg(1, 7'h27, 8'h02);
    creg(1, 7'h33, 8'h00);
    cmp("filter", 24'h1, {23'h0, filt});
    wr(1, 7'h11, 8'h80);
    cmp("busy", 24'h1, {23'h0, trim_busy_o});
    cmp("cfg", 24'h0, {16'h0, cfg.control_two});
    creg(1, 7'h11, 8'h80);
    creg(1, 7'h0D, 8'h01);
    creg(0, 7'h0D, 8'h01);
    wait_trim();
    summarize();
  end
endmodule

//--- src/baro_event_regs.sv
// Operation
// - eight-bit registers selected by seven-bit address
// - calibration store reloads itself at power-up
// - master enable, reset clear, gates all events
// - latch enabled holds event until source read
// - low enable raises event below negative threshold
// - high enable raises event above positive threshold
// - threshold is sixteen-bit unsigned, two byte registers
// - threshold applies as plus/minus value over sixteen
// - reference modes compare measured minus stored reference
// - auto-zero captures reference, output and compare subtract
// - auto-zero bit self-clears after next conversion
// - auto-zero clear restores normal output, clears reference
// - event-reference mode: output subtracts offset pair only
// - event-reference bit self-clears; clear bit leaves mode
// - auto-increment advances address after each byte
`timescale 1ns/100ps
`include "baro_regs_defs.svh"

module baro_event_regs #(
  parameter logic [7:0] IDENT_VALUE = 8'h5A, // arbitrary value
  parameter int TRIM_WORDS = `TRIM_WORDS
) (
  input wire logic core_clk_i, // 25 MHz core clock
  input wire logic resetn_i, // async reset, active low
  input wire baro_regs_pkg::reg_req_s req_i, // byte access from serial front end
  output logic [7:0] rdata_o, // read byte
  output logic rvalid_o, // pulse: rdata_o valid
  input wire logic conv_valid_i, // pulse: new conversion ready
  input wire baro_regs_pkg::conv_s conv_i, // raw conversion data
  output baro_regs_pkg::core_cfg_s cfg_o, // configuration to the core
  output logic [23:0] pressure_o, // pressure as shown to host
  output logic event_o, // threshold event active
  output logic filter_reset_o, // pulse: filter clear read
  input wire logic [$clog2(TRIM_WORDS)-1:0] trim_addr_i, // trim read address
  output logic [7:0] trim_data_o, // trim word
  output logic trim_busy_o // trim reload running
);
  import baro_regs_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // unsigned 24-bit minus unsigned 24-bit, signed 25-bit result
  function automatic logic signed [24:0] sub25(input logic [23:0] a, input logic [23:0] b);
    sub25 = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction

  // replace one byte lane of a 24-bit word
  function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] lane,
                                            input logic [7:0] b);
    logic [23:0] r;
    r = w;
    case (lane)
      2'd0: r[7:0] = b;
      2'd1: r[15:8] = b;
      default: r[23:16] = b;
    endcase
    put_byte = r;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [6:0] ptr_q, ptr_d;
  logic [7:0] evt_cfg_q;
  logic [15:0] ths_q;
  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, queue_cfg_q, res_cfg_q;
  logic [23:0] ref_q, ref_d;
  logic [15:0] offs_q;
  logic az_mode_q, arp_mode_q;
  logic hi_flag_q, lo_flag_q;
  logic p_avail_q, t_avail_q;
  logic [23:0] press_q;
  logic [15:0] temp_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic filt_q;

  // ------------------------------------------------------------
  // address pointer
  // ------------------------------------------------------------
  // the front end decodes the serial frame; here a start strobe uses its
  // own address and other strobes use the pointer, which advances only with auto-increment on
  wire auto_inc = ctrl2_q[`CTRL2_AUTO_INC];
  wire byte_done = req_i.wr | req_i.rd;
  wire [6:0] acc_addr = req_i.start ? req_i.addr : ptr_q;

  always_comb begin
    ptr_d = acc_addr;
    if (byte_done && auto_inc) ptr_d = acc_addr + 7'd1;
  end

  // ------------------------------------------------------------
  // write and read decode
  // ------------------------------------------------------------
  // only listed read/write addresses accept data; reserved, unlisted
  // and read-only addresses drop writes silently
  wire wr = req_i.wr;
  wire wr_cfg = wr && (acc_addr == `OFS_EVT_CFG);
  wire wr_ths_lo = wr && (acc_addr == `OFS_THS_LO);
  wire wr_ths_hi = wr && (acc_addr == `OFS_THS_HI);
  wire wr_ctrl1 = wr && (acc_addr == `OFS_CTRL1);
  wire wr_ctrl2 = wr && (acc_addr == `OFS_CTRL2);
  wire wr_ctrl3 = wr && (acc_addr == `OFS_CTRL3);
  wire wr_queue = wr && (acc_addr == `OFS_QUEUE_CFG);
  wire wr_ref_xl = wr && (acc_addr == `OFS_REF_XL);
  wire wr_ref_l = wr && (acc_addr == `OFS_REF_L);
  wire wr_ref_h = wr && (acc_addr == `OFS_REF_H);
  wire wr_offs_l = wr && (acc_addr == `OFS_OFFS_L);
  wire wr_offs_h = wr && (acc_addr == `OFS_OFFS_H);
  wire wr_res = wr && (acc_addr == `OFS_RES_CFG);
  wire rd_src = req_i.rd && (acc_addr == `OFS_EVT_SRC);
  wire rd_press_h = req_i.rd && (acc_addr == `OFS_PRESS_H);
  wire rd_temp_h = req_i.rd && (acc_addr == `OFS_TEMP_H);
  wire rd_filt = req_i.rd && (acc_addr == `OFS_FILT_CLR);

  // ------------------------------------------------------------
  // event configuration fields
  // ------------------------------------------------------------
  wire master_en = evt_cfg_q[`CFG_MASTER];
  wire latch_en = evt_cfg_q[`CFG_LATCH];
  wire low_en = evt_cfg_q[`CFG_LOW];
  wire high_en = evt_cfg_q[`CFG_HIGH];
  wire az_req = evt_cfg_q[`CFG_AZ];
  wire arp_req = evt_cfg_q[`CFG_REF_CAPTURE];
  // clear bits act on the write itself and are never stored
  wire az_clear = wr_cfg && req_i.wdata[`CFG_AZ_CLEAR];
  wire arp_clear = wr_cfg && req_i.wdata[`CFG_REF_CLEAR];

  // ------------------------------------------------------------
  // reference handling and comparison
  // ------------------------------------------------------------
  // a capture request takes this conversion as the new reference
  wire capture = conv_valid_i && (az_req || arp_req);
  wire [23:0] ref_use = capture ? conv_i.pressure : ref_q;
  wire ref_mode = az_mode_q || arp_mode_q || capture;
  // outside the reference modes the raw pressure is compared
  wire signed [24:0] compared_pressure = ref_mode ?
      sub25(conv_i.pressure, ref_use) : sub25(conv_i.pressure, `RST_REF);
  // threshold over 16 in hPa, re-expressed in pressure lsbs; the
  // shift is what ties the threshold lsb to the pressure lsb
  wire [24:0] ths_wide = 25'(ths_q) << `THS_SHIFT;
  wire signed [24:0] ths_pos = $signed(ths_wide);
  wire signed [24:0] ths_neg = -ths_pos;
  wire hit_hi = master_en && high_en && (compared_pressure > ths_pos);
  wire hit_lo = master_en && low_en && (compared_pressure < ths_neg);

  // ------------------------------------------------------------
  // pressure shown to the host
  // ------------------------------------------------------------
  wire signed [24:0] out_az = sub25(conv_i.pressure, ref_use);
  wire signed [24:0] out_arp = sub25(conv_i.pressure, {8'h00, offs_q});
  wire az_out = az_mode_q || (conv_valid_i && az_req);
  wire arp_out = arp_mode_q || (conv_valid_i && arp_req);
  wire [23:0] press_new = az_out ? out_az[23:0] :
                          arp_out ? out_arp[23:0] : conv_i.pressure;

  // ------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------
  // latched: a read of the source clears, but a hit in the same
  // cycle wins so no event is lost; unlatched: follow each result
  wire hi_flag_d = latch_en ?
      ((hi_flag_q && !rd_src) || (conv_valid_i && hit_hi)) :
      (conv_valid_i ? hit_hi : hi_flag_q);
  wire lo_flag_d = latch_en ?
      ((lo_flag_q && !rd_src) || (conv_valid_i && hit_lo)) :
      (conv_valid_i ? hit_lo : lo_flag_q);
  wire [7:0] src_byte = {5'b0_0000, hi_flag_q | lo_flag_q, lo_flag_q, hi_flag_q};

  // ------------------------------------------------------------
  // event configuration register
  // ------------------------------------------------------------
  // request bits self-clear on the first conversion; a request
  // written in that very cycle is kept for the next one
  logic [7:0] evt_cfg_d;
  always_comb begin
    evt_cfg_d = evt_cfg_q;
    if (conv_valid_i) begin
      evt_cfg_d[`CFG_AZ] = 1'b0;
      evt_cfg_d[`CFG_REF_CAPTURE] = 1'b0;
    end
    if (wr_cfg) begin
      evt_cfg_d = req_i.wdata;
      evt_cfg_d[`CFG_AZ_CLEAR] = 1'b0;
      evt_cfg_d[`CFG_REF_CLEAR] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // reference register: host bytes, capture, clear
  // ------------------------------------------------------------
  always_comb begin
    ref_d = ref_q;
    if (wr_ref_xl) ref_d = put_byte(ref_q, 2'd0, req_i.wdata);
    if (wr_ref_l) ref_d = put_byte(ref_q, 2'd1, req_i.wdata);
    if (wr_ref_h) ref_d = put_byte(ref_q, 2'd2, req_i.wdata);
    if (az_clear) ref_d = `RST_REF;
    if (capture) ref_d = conv_i.pressure;
  end

  // ------------------------------------------------------------
  // configuration and mode registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_q <= 7'h00;
      evt_cfg_q <= `RST_BYTE;
      ths_q <= {`RST_BYTE, `RST_BYTE};
      ref_q <= `RST_REF;
      offs_q <= {`RST_BYTE, `RST_BYTE};
    end else begin
      ptr_q <= ptr_d;
      evt_cfg_q <= evt_cfg_d;
      if (wr_ths_lo) ths_q[7:0] <= req_i.wdata;
      if (wr_ths_hi) ths_q[15:8] <= req_i.wdata;
      ref_q <= ref_d;
      if (wr_offs_l) offs_q[7:0] <= req_i.wdata;
      if (wr_offs_h) offs_q[15:8] <= req_i.wdata;
    end
  end

  // core configuration bytes; boot bit reads back while reloading
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl1_q <= `RST_BYTE;
      ctrl2_q <= `RST_CTRL2;
      ctrl3_q <= `RST_BYTE;
      queue_cfg_q <= `RST_BYTE;
      res_cfg_q <= `RST_BYTE;
    end else begin
      if (wr_ctrl1) ctrl1_q <= req_i.wdata;
      if (wr_ctrl2) ctrl2_q <= req_i.wdata & ~(8'h01 << `CTRL2_BOOT);
      if (wr_ctrl3) ctrl3_q <= req_i.wdata;
      if (wr_queue) queue_cfg_q <= req_i.wdata;
      if (wr_res) res_cfg_q <= req_i.wdata;
    end
  end

  // reference modes: entered on capture, left only by the clear bits
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      az_mode_q <= 1'b0;
      arp_mode_q <= 1'b0;
    end else begin
      az_mode_q <= (az_mode_q && !az_clear) || (conv_valid_i && az_req);
      arp_mode_q <= (arp_mode_q && !arp_clear) || (conv_valid_i && arp_req);
    end
  end

  // ------------------------------------------------------------
  // results and status
  // ------------------------------------------------------------
  // data-available bits drop when the top byte is read; a new
  // sample in the same cycle wins
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      press_q <= 24'h00_0000;
      temp_q <= 16'h0000;
      hi_flag_q <= 1'b0;
      lo_flag_q <= 1'b0;
      p_avail_q <= 1'b0;
      t_avail_q <= 1'b0;
    end else begin
      if (conv_valid_i) press_q <= press_new;
      if (conv_valid_i) temp_q <= conv_i.temperature;
      hi_flag_q <= hi_flag_d;
      lo_flag_q <= lo_flag_d;
      p_avail_q <= conv_valid_i || (p_avail_q && !rd_press_h);
      t_avail_q <= conv_valid_i || (t_avail_q && !rd_temp_h);
    end
  end

  // ------------------------------------------------------------
  // trim store, reloaded at power-up and on boot request
  // ------------------------------------------------------------
  wire boot_req = wr_ctrl2 && req_i.wdata[`CTRL2_BOOT];
  wire trim_busy;

  trim_loader #(
    .WORDS(TRIM_WORDS)
  ) u_trim (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .boot_req_i(boot_req),
    .trim_addr_i(trim_addr_i),
    .trim_data_o(trim_data_o),
    .busy_o(trim_busy)
  );

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------
  // unlisted and reserved addresses read zero; queue state reads zero
  // because the queue lives elsewhere
  logic [7:0] rd_mux;
  always_comb begin
    case (acc_addr)
      `OFS_EVT_CFG: rd_mux = evt_cfg_q;
      `OFS_THS_LO: rd_mux = ths_q[7:0];
      `OFS_THS_HI: rd_mux = ths_q[15:8];
      `OFS_IDENT: rd_mux = IDENT_VALUE;
      `OFS_CTRL1: rd_mux = ctrl1_q;
      `OFS_CTRL2: rd_mux = ctrl2_q | ({7'h00, trim_busy} << `CTRL2_BOOT);
      `OFS_CTRL3: rd_mux = ctrl3_q;
      `OFS_QUEUE_CFG: rd_mux = queue_cfg_q;
      `OFS_REF_XL: rd_mux = ref_q[7:0];
      `OFS_REF_L: rd_mux = ref_q[15:8];
      `OFS_REF_H: rd_mux = ref_q[23:16];
      `OFS_OFFS_L: rd_mux = offs_q[7:0];
      `OFS_OFFS_H: rd_mux = offs_q[15:8];
      `OFS_RES_CFG: rd_mux = res_cfg_q;
      `OFS_EVT_SRC: rd_mux = src_byte;
      `OFS_QUEUE_STATE: rd_mux = `RST_BYTE;
      `OFS_SAMPLE_STATE: rd_mux = {6'b00_0000, t_avail_q, p_avail_q};
      `OFS_PRESS_XL: rd_mux = press_q[7:0];
      `OFS_PRESS_L: rd_mux = press_q[15:8];
      `OFS_PRESS_H: rd_mux = press_q[23:16];
      `OFS_TEMP_L: rd_mux = temp_q[7:0];
      `OFS_TEMP_H: rd_mux = temp_q[15:8];
      `OFS_FILT_CLR: rd_mux = `RST_BYTE;
      default: rd_mux = `RST_BYTE;
    endcase
  end

  // read data and side-effect pulses, one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= `RST_BYTE;
      rvalid_q <= 1'b0;
      filt_q <= 1'b0;
    end else begin
      if (req_i.rd) rdata_q <= rd_mux;
      rvalid_q <= req_i.rd;
      filt_q <= rd_filt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign cfg_o = '{control_one: ctrl1_q, control_two: ctrl2_q, control_three: ctrl3_q,
                   queue_config: queue_cfg_q, resolution_config: res_cfg_q};
  assign pressure_o = press_q;
  assign event_o = src_byte[`SRC_ANY];
  assign filter_reset_o = filt_q;
  assign trim_busy_o = trim_busy;

endmodule

//--- src/baro_regs_defs.svh
`ifndef BARO_REGS_DEFS_SVH
`define BARO_REGS_DEFS_SVH

// ------------------------------------------------------------
// register offsets (7-bit register address space)
// ------------------------------------------------------------
`define OFS_EVT_CFG 7'h0B
`define OFS_THS_LO 7'h0C
`define OFS_THS_HI 7'h0D
`define OFS_IDENT 7'h0F
`define OFS_CTRL1 7'h10
`define OFS_CTRL2 7'h11
`define OFS_CTRL3 7'h12
`define OFS_QUEUE_CFG 7'h14
`define OFS_REF_XL 7'h15
`define OFS_REF_L 7'h16
`define OFS_REF_H 7'h17
`define OFS_OFFS_L 7'h18
`define OFS_OFFS_H 7'h19
`define OFS_RES_CFG 7'h1A
`define OFS_EVT_SRC 7'h25
`define OFS_QUEUE_STATE 7'h26
`define OFS_SAMPLE_STATE 7'h27
`define OFS_PRESS_XL 7'h28
`define OFS_PRESS_L 7'h29
`define OFS_PRESS_H 7'h2A
`define OFS_TEMP_L 7'h2B
`define OFS_TEMP_H 7'h2C
`define OFS_FILT_CLR 7'h33

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CTRL2 8'h10
`define RST_REF 24'h00_0000

// ------------------------------------------------------------
// event configuration fields
// ------------------------------------------------------------
`define CFG_REF_CAPTURE 7
`define CFG_REF_CLEAR 6
`define CFG_AZ 5
`define CFG_AZ_CLEAR 4
`define CFG_MASTER 3
`define CFG_LATCH 2
`define CFG_LOW 1
`define CFG_HIGH 0

// other fields
`define CTRL2_BOOT 7
`define CTRL2_AUTO_INC 4
`define SRC_ANY 2
`define SRC_LOW 1
`define SRC_HIGH 0
`define STATE_T_AVAIL 1
`define STATE_P_AVAIL 0

// threshold lsb is 1/16 hPa, pressure lsb 1/4096 hPa: scale by 2^8
`define THS_SHIFT 8
`define TRIM_WORDS 8

`endif

//--- src/baro_regs_pkg.sv
package baro_regs_pkg;

  // one finished conversion from the sensor core
  typedef struct packed {
    logic [23:0] pressure;
    logic [15:0] temperature;
  } conv_s;

  // configuration bytes handed to the sensor core
  typedef struct packed {
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] control_three;
    logic [7:0] queue_config;
    logic [7:0] resolution_config;
  } core_cfg_s;

  // host register access, one byte per strobe
  typedef struct packed {
    logic start;
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [0:0] {
    TRIM_IDLE,
    TRIM_LOAD
  } trim_state_e;

endpackage

//--- src/trim_loader.sv
`timescale 1ns/100ps
`include "baro_regs_defs.svh"

module trim_loader #(
  parameter int WORDS = `TRIM_WORDS
) (
  input wire logic core_clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  input wire logic boot_req_i, // pulse: reload the trim store
  input wire logic [$clog2(WORDS)-1:0] trim_addr_i, // core read address
  output logic [7:0] trim_data_o, // registered trim word
  output logic busy_o // reload in progress
);
  import baro_regs_pkg::*;

  localparam int AW = $clog2(WORDS);
  localparam logic [AW-1:0] LAST = AW'(WORDS - 1);

  // factory trim values; arbitrary neutral pattern, not a real device's
  function automatic logic [7:0] factory_word(input logic [AW-1:0] idx);
    factory_word = 8'h80 ^ 8'(idx);
  endfunction

  logic [7:0] store_q [WORDS];
  trim_state_e state_q, state_d;
  logic [AW-1:0] idx_q;
  wire loading = (state_q == TRIM_LOAD);

  // --------------------------------------------------------
  // reload sequencer: runs after reset and on each boot request made while idle
  // --------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      TRIM_IDLE: if (boot_req_i) state_d = TRIM_LOAD;
      TRIM_LOAD: if (idx_q == LAST) state_d = TRIM_IDLE;
      default: state_d = TRIM_IDLE;
    endcase
  end

  // reset lands in load so the store refills at power-up
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= TRIM_LOAD;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q <= loading ? idx_q + 1'b1 : '0;
    end
  end

  // store has no reset: every word is rewritten before busy drops
  always_ff @(posedge core_clk_i) begin
    if (loading) store_q[idx_q] <= factory_word(idx_q);
  end

  // read port, one cycle latency
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) trim_data_o <= '0;
    else trim_data_o <= store_q[trim_addr_i];
  end

  assign busy_o = loading;

endmodule
